// file: hdl/fbo_cfg.svh
`ifndef FBO_CFG_SVH
`define FBO_CFG_SVH

// ==========================================================
// object dictionary indices
`define FBO_IDX_BOOT_POS    16'h205a
`define FBO_IDX_INPUT_MODE  16'h205b
`define FBO_IDX_READY_DLY   16'h2084
`define FBO_IDX_AVAIL       16'h2101
`define FBO_IDX_CONTROL     16'h2102
`define FBO_IDX_STATUS      16'h2103
`define FBO_SUB_COUNT       8'h00
`define FBO_SUB_MASK        8'h01
`define FBO_SUB_ENABLED     8'h02

// ==========================================================
// presets
`define FBO_RST_BOOT_POS    32'h0000_0000
`define FBO_RST_INPUT_MODE  32'h0000_0000
`define FBO_RST_READY_DLY   32'h0000_0000
`define FBO_RST_AVAIL       32'h0019_0009
`define FBO_RST_CONTROL     32'h0019_0009
`define FBO_RST_MASK        32'h0000_0008
`define FBO_RST_ENABLED     32'h0019_0009
`define FBO_STATUS_COUNT    32'h0000_0002

// ==========================================================
// fieldbus map bit positions
`define FBO_BIT_USB                    0
`define FBO_BIT_RS485                  1
`define FBO_BIT_RS232                  2
`define FBO_BIT_CAN                    3
`define FBO_BIT_ETHERNET_PORT          4
`define FBO_BIT_REALTIME_ETHERNET      5
`define FBO_BIT_SPI                    6
`define FBO_BIT_SERIAL_REGISTER_PROTO  16
`define FBO_BIT_TCP_REGISTER_PROTO     17
`define FBO_BIT_INDUSTRIAL_IP_PROTO    18
`define FBO_IFACE_LSB                  0
`define FBO_IFACE_MSB                  15
`define FBO_PROTO_LSB                  16
`define FBO_PROTO_MSB                  31

// ==========================================================
// timing
`define FBO_CLK_HZ          100000000
`define FBO_MS_PER_S        1000
`define FBO_CYC_PER_MS      (`FBO_CLK_HZ / `FBO_MS_PER_S)

// ==========================================================
// input mode codes and save categories
`define FBO_MODE_STEP_DIR   32'h0000_0000
`define FBO_MODE_ROTATION   32'h0000_0001
`define FBO_CAT_COMM        2'h1

`endif

// file: hdl/fbo_pkg.sv
package fbo_pkg;

  typedef logic [31:0] fbo_word_t;
  typedef logic [15:0] fbo_index_t;
  typedef logic [7:0]  fbo_sub_t;
  typedef logic [1:0]  fbo_cat_t;

  // readiness timer states
  typedef enum logic [1:0] {
    FBO_TM_COUNT = 2'b01,
    FBO_TM_READY = 2'b10
  } fbo_tm_state_t;

endpackage : fbo_pkg

// file: hdl/fbo_ready_timer.sv
`timescale 1ns/1ns
`include "fbo_cfg.svh"

module fbo_ready_timer #(
  parameter int unsigned CYC_PER_MS = `FBO_CYC_PER_MS
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // delay in milliseconds, live value
  input  wire fbo_pkg::fbo_word_t delay_ms,
  // readiness
  output logic                  ready
);
  import fbo_pkg::*;

  typedef struct packed {
    fbo_tm_state_t st;
    logic [31:0]   cyc;
    logic [31:0]   ms;
    logic          rdy;
  } fbo_tm_reg_t;

  fbo_tm_reg_t r_q;
  fbo_tm_reg_t r_d;

  // ========================================================
  // millisecond divider and delay count
  always_comb
  begin
    r_d = r_q;
    case (r_q.st)
      FBO_TM_COUNT:
      begin
        // compare against the live value so a write while waiting
        // shortens or stretches the hold-off
        if (r_q.ms >= delay_ms)
        begin
          r_d.st  = FBO_TM_READY;
          r_d.rdy = 1'b1;
        end
        else if (r_q.cyc == 32'(CYC_PER_MS - 1))
        begin
          r_d.cyc = '0;
          r_d.ms  = r_q.ms + 32'h0000_0001;
        end
        else
        begin
          r_d.cyc = r_q.cyc + 32'h0000_0001;
        end
      end
      FBO_TM_READY:
      begin
        r_d.rdy = 1'b1;
      end
      default:
      begin
        r_d.st = FBO_TM_COUNT;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      r_q.st  <= FBO_TM_COUNT;
      r_q.cyc <= '0;
      r_q.ms  <= '0;
      r_q.rdy <= 1'b0;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  assign ready = r_q.rdy;

endmodule : fbo_ready_timer

// file: hdl/fbo_object_bank.sv
`timescale 1ns/1ns
`include "fbo_cfg.svh"

module fbo_object_bank #(
  parameter int unsigned CYC_PER_MS = `FBO_CYC_PER_MS
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 srst,
  // object dictionary access from the fieldbus master
  input  wire logic                 od_req,
  input  wire logic                 od_write,
  input  wire fbo_pkg::fbo_index_t  od_index,
  input  wire fbo_pkg::fbo_sub_t    od_sub,
  input  wire fbo_pkg::fbo_word_t   od_wdata,
  output logic                      od_ack,
  output logic                      od_abort,
  output fbo_pkg::fbo_word_t        od_rdata,
  // encoder position, sampled once after reset
  input  wire fbo_pkg::fbo_word_t   enc_position,
  // controls and status towards the drive
  output logic                      rotation_mode,
  output fbo_pkg::fbo_word_t        fieldbus_enabled,
  output logic                      func_ready,
  // non-volatile save request for the control word
  output logic                      nv_save_stb,
  output fbo_pkg::fbo_cat_t         nv_save_cat,
  output fbo_pkg::fbo_word_t        nv_save_data
);
  import fbo_pkg::*;

  typedef struct packed {
    logic      cap_done;
    fbo_word_t boot_encoder_position;
    fbo_word_t input_mode_select;
    fbo_word_t powerup_ready_delay;
    fbo_word_t fieldbus_enable_control;
    fbo_word_t fieldbus_enabled_status;
    logic      ack;
    logic      abort;
    fbo_word_t rdata;
    logic      save_stb;
    fbo_word_t save_data;
  } fbo_bank_reg_t;

  fbo_bank_reg_t r_q;
  fbo_bank_reg_t r_d;

  // ========================================================
  // helpers
  function automatic logic is_var(input fbo_index_t idx,
                                  input fbo_sub_t   sub,
                                  input fbo_index_t want);
    is_var = (idx == want) && (sub == `FBO_SUB_COUNT);
  endfunction : is_var

  // only masked bits take the written value
  function automatic fbo_word_t merge_enable(input fbo_word_t cur,
                                             input fbo_word_t req,
                                             input fbo_word_t msk);
    merge_enable = (cur & ~msk) | (req & msk);
  endfunction : merge_enable

  // ========================================================
  // fieldbus map layout
  localparam fbo_word_t IFACE_BITS =
    (32'h0000_0001 << `FBO_BIT_USB) |
    (32'h0000_0001 << `FBO_BIT_RS485) |
    (32'h0000_0001 << `FBO_BIT_RS232) |
    (32'h0000_0001 << `FBO_BIT_CAN) |
    (32'h0000_0001 << `FBO_BIT_ETHERNET_PORT) |
    (32'h0000_0001 << `FBO_BIT_REALTIME_ETHERNET) |
    (32'h0000_0001 << `FBO_BIT_SPI);
  localparam fbo_word_t PROTO_BITS =
    (32'h0000_0001 << `FBO_BIT_SERIAL_REGISTER_PROTO) |
    (32'h0000_0001 << `FBO_BIT_TCP_REGISTER_PROTO) |
    (32'h0000_0001 << `FBO_BIT_INDUSTRIAL_IP_PROTO);
  // only assigned map bits may ever switch, so a wider mask in a
  // later build cannot reach spare bits; interfaces low, protocols high
  localparam fbo_word_t SWITCH_BITS =
    `FBO_RST_MASK & ((IFACE_BITS & 32'h0000_ffff) |
                     (PROTO_BITS & 32'hffff_0000));

  // ========================================================
  // access decode and object update
  always_comb
  begin
    r_d          = r_q;
    r_d.ack      = 1'b0;
    r_d.abort    = 1'b0;
    r_d.save_stb = 1'b0;
    // boot snapshot taken on the first cycle after reset
    if (!r_q.cap_done)
    begin
      r_d.cap_done              = 1'b1;
      r_d.boot_encoder_position = enc_position;
    end
    if (od_req)
    begin
      r_d.ack   = 1'b1;
      r_d.rdata = '0;
      if (is_var(od_index, od_sub, `FBO_IDX_BOOT_POS))
      begin
        r_d.rdata = r_q.boot_encoder_position;
        r_d.abort = od_write;
      end
      else if (is_var(od_index, od_sub, `FBO_IDX_INPUT_MODE))
      begin
        r_d.rdata = r_q.input_mode_select;
        if (od_write)
        begin
          r_d.input_mode_select = od_wdata;
        end
      end
      else if (is_var(od_index, od_sub, `FBO_IDX_READY_DLY))
      begin
        r_d.rdata = r_q.powerup_ready_delay;
        if (od_write)
        begin
          r_d.powerup_ready_delay = od_wdata;
        end
      end
      else if (is_var(od_index, od_sub, `FBO_IDX_AVAIL))
      begin
        r_d.rdata = `FBO_RST_AVAIL;
        r_d.abort = od_write;
      end
      else if (is_var(od_index, od_sub, `FBO_IDX_CONTROL))
      begin
        r_d.rdata = r_q.fieldbus_enable_control;
        if (od_write)
        begin
          r_d.fieldbus_enable_control = od_wdata;
          r_d.fieldbus_enabled_status =
            merge_enable(r_q.fieldbus_enabled_status, od_wdata,
                         SWITCH_BITS);
          r_d.save_stb  = 1'b1;
          r_d.save_data = od_wdata;
        end
      end
      else if (od_index == `FBO_IDX_STATUS)
      begin
        // the whole array is read-only
        r_d.abort = od_write;
        case (od_sub)
          `FBO_SUB_COUNT:   r_d.rdata = `FBO_STATUS_COUNT;
          `FBO_SUB_MASK:    r_d.rdata = `FBO_RST_MASK;
          `FBO_SUB_ENABLED: r_d.rdata = r_q.fieldbus_enabled_status;
          default:          r_d.abort = 1'b1;
        endcase
      end
      else
      begin
        r_d.abort = 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      r_q.cap_done                <= 1'b0;
      r_q.boot_encoder_position   <= `FBO_RST_BOOT_POS;
      r_q.input_mode_select       <= `FBO_RST_INPUT_MODE;
      r_q.powerup_ready_delay     <= `FBO_RST_READY_DLY;
      r_q.fieldbus_enable_control <= `FBO_RST_CONTROL;
      r_q.fieldbus_enabled_status <= `FBO_RST_ENABLED;
      r_q.ack                     <= 1'b0;
      r_q.abort                   <= 1'b0;
      r_q.rdata                   <= '0;
      r_q.save_stb                <= 1'b0;
      r_q.save_data               <= '0;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // ========================================================
  // readiness hold-off
  fbo_ready_timer #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_ready (
    .clk      (clk),
    .srst     (srst),
    .delay_ms (r_q.powerup_ready_delay),
    .ready    (func_ready)
  );

  // ========================================================
  // outputs
  assign od_ack           = r_q.ack;
  assign od_abort         = r_q.abort;
  assign od_rdata         = r_q.rdata;
  // any nonzero value other than 1 falls back to step/direction
  assign rotation_mode    =
    (r_q.input_mode_select == `FBO_MODE_ROTATION);
  // bit layout per the map word: low half interfaces, high protocols
  assign fieldbus_enabled = r_q.fieldbus_enabled_status;
  assign nv_save_stb      = r_q.save_stb;
  assign nv_save_cat      = `FBO_CAT_COMM;
  assign nv_save_data     = r_q.save_data;

endmodule : fbo_object_bank

// file: tb/fbo_object_bank_asserts.sv
`timescale 1ns/1ns
`include "fbo_cfg.svh"
// ==========================================================
// port checks of the object bank
module fbo_object_bank_asserts
  import fbo_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = 10
) (
  // clock and reset
  input wire logic                clk,
  input wire logic                srst,
  // access
  input wire logic                od_req,
  input wire logic                od_write,
  input wire fbo_pkg::fbo_index_t od_index,
  input wire fbo_pkg::fbo_sub_t   od_sub,
  input wire fbo_pkg::fbo_word_t  od_wdata,
  input wire logic                od_ack,
  input wire logic                od_abort,
  input wire fbo_pkg::fbo_word_t  od_rdata,
  // drive side
  input wire logic                rotation_mode,
  input wire fbo_pkg::fbo_word_t  fieldbus_enabled,
  input wire logic                func_ready,
  input wire logic                nv_save_stb,
  input wire fbo_pkg::fbo_cat_t   nv_save_cat,
  input wire fbo_pkg::fbo_word_t  nv_save_data
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  wire logic wr0 = od_req && od_write && od_sub == 8'h00;
  wire logic ctl_w = wr0 && od_index == `FBO_IDX_CONTROL;
  wire logic mode_w = wr0 && od_index == `FBO_IDX_INPUT_MODE;
  wire logic st_rd = od_req && !od_write && od_index == `FBO_IDX_STATUS;
  wire logic ro_w = od_req && od_write && (od_index == `FBO_IDX_BOOT_POS
    || od_index == `FBO_IDX_AVAIL || od_index == `FBO_IDX_STATUS);
  ro_write_refused_a: assert property (
    ro_w |=> od_ack && od_abort) else $error("read-only write accepted");
  ack_timing_a: assert property (od_ack == $past(od_req))
    else $error("access not answered in one cycle");
  mask_read_a: assert property (st_rd && od_sub == 8'h01
    |=> od_ack && !od_abort && od_rdata == `FBO_RST_MASK)
    else $error("switchable mask misread");
  count_read_a: assert property (st_rd && od_sub == 8'h00
    |=> od_rdata == `FBO_STATUS_COUNT) else $error("entry count misread");
  enabled_read_a: assert property (st_rd && od_sub == 8'h02
    |=> od_rdata == fieldbus_enabled) else $error("enabled status misread");
  mode_follow_a: assert property (mode_w
    |=> rotation_mode == ($past(od_wdata) == `FBO_MODE_ROTATION))
    else $error("rotation mode wrong");
  save_strobe_a: assert property (ctl_w |=> nv_save_stb
    && nv_save_data == $past(od_wdata)) else $error("control not saved");
  save_cat_a: assert property (
    nv_save_stb |-> nv_save_cat == `FBO_CAT_COMM)
    else $error("wrong save category");
  enable_mask_a: assert property (ctl_w |=> fieldbus_enabled ==
    ($past(fieldbus_enabled) & ~`FBO_RST_MASK
    | $past(od_wdata) & `FBO_RST_MASK))
    else $error("unmasked bit switched");
  enable_still_a: assert property (
    !ctl_w |=> $stable(fieldbus_enabled))
    else $error("enabled set moved");
  ready_hold_a: assert property (func_ready |=> func_ready)
    else $error("readiness dropped");
  cover property (ctl_w);
  cover property (ro_w);
  cover property ($rose(rotation_mode));
endmodule : fbo_object_bank_asserts

bind fbo_object_bank fbo_object_bank_asserts #(.CYC_PER_MS(CYC_PER_MS))
  fbo_object_bank_asserts_i (.clk(clk), .srst(srst), .od_req(od_req),
  .od_write(od_write), .od_index(od_index), .od_sub(od_sub),
  .od_wdata(od_wdata), .od_ack(od_ack), .od_abort(od_abort),
  .od_rdata(od_rdata), .rotation_mode(rotation_mode),
  .fieldbus_enabled(fieldbus_enabled), .func_ready(func_ready),
  .nv_save_stb(nv_save_stb), .nv_save_cat(nv_save_cat),
  .nv_save_data(nv_save_data));

// file: tb/fbo_master_model.sv
`timescale 1ns/1ns
// ==========================================================
// fieldbus master: one request pulse per access
module fbo_master_model (
  // clock and answer
  input  wire logic               clk,
  input  wire logic               od_ack,
  input  wire logic               od_abort,
  input  wire fbo_pkg::fbo_word_t od_rdata,
  // request
  output logic                    od_req,
  output logic                    od_write,
  output fbo_pkg::fbo_index_t     od_index,
  output fbo_pkg::fbo_sub_t       od_sub,
  output fbo_pkg::fbo_word_t      od_wdata
);
  import fbo_pkg::*;
  initial
  begin
    od_req = 1'b0;
    {od_write, od_index, od_sub, od_wdata} = '0;
  end
  task automatic access(input logic w, input fbo_index_t i, input fbo_sub_t s,
    input fbo_word_t d, output fbo_word_t rd, output logic ab);
    int n;
    @(negedge clk);
    od_req = 1'b1;
    {od_write, od_index, od_sub, od_wdata} = {w, i, s, d};
    @(negedge clk);
    // released lines flip so a late sample cannot pass by luck
    od_req = 1'b0;
    {od_write, od_index, od_sub, od_wdata} = ~{w, i, s, d};
    n = 0;
    while (od_ack !== 1'b1 && n < 4)
    begin
      @(negedge clk);
      n++;
    end
    rd = od_rdata;
    ab = (n < 4) ? od_abort : 1'bx;
  endtask : access
endmodule : fbo_master_model

// file: tb/tb_top.sv
`timescale 1ns/1ns
`include "fbo_cfg.svh"
// ==========================================================
// bench: reference map against the object bank
module tb_top;
  import fbo_pkg::*;
  logic clk, srst, od_req, od_write, od_ack, od_abort;
  logic rotation_mode, func_ready, nv_save_stb;
  fbo_index_t od_index;
  fbo_sub_t od_sub;
  fbo_cat_t nv_save_cat;
  fbo_word_t od_wdata, od_rdata, enc_position, fieldbus_enabled, nv_save_data;
  fbo_word_t mdl [logic [23:0]];
  bit ro [logic [23:0]];
  logic [23:0] keys [$] = '{24'h20_5a00, 24'h20_5b00, 24'h20_8400,
    24'h21_0100, 24'h21_0200, 24'h21_0300, 24'h21_0301, 24'h21_0302};
  int n_mismatch, checks;
  fbo_object_bank #(.CYC_PER_MS(10)) fbo_object_bank_i (.clk(clk),
    .srst(srst), .od_req(od_req), .od_write(od_write), .od_index(od_index),
    .od_sub(od_sub), .od_wdata(od_wdata), .od_ack(od_ack),
    .od_abort(od_abort), .od_rdata(od_rdata), .enc_position(enc_position),
    .rotation_mode(rotation_mode), .fieldbus_enabled(fieldbus_enabled),
    .func_ready(func_ready), .nv_save_stb(nv_save_stb),
    .nv_save_cat(nv_save_cat), .nv_save_data(nv_save_data));
  fbo_master_model fbo_master_model_i (.clk(clk), .od_ack(od_ack),
    .od_abort(od_abort), .od_rdata(od_rdata), .od_req(od_req),
    .od_write(od_write), .od_index(od_index), .od_sub(od_sub),
    .od_wdata(od_wdata));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    #100000;
    n_mismatch++;
    results();
  end
  task automatic results();
    if (n_mismatch == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results
  task automatic chk(input fbo_word_t seen, input fbo_word_t exp);
    checks++;
    if (seen !== exp)
    begin
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
      n_mismatch++;
    end
  endtask : chk
  task automatic rst(input int n);
    srst = 1'b1;
    repeat (n) @(negedge clk);
    srst = 1'b0;
    mdl = '{24'h20_5a00: enc_position, 24'h20_5b00: `FBO_RST_INPUT_MODE,
      24'h20_8400: `FBO_RST_READY_DLY, 24'h21_0100: `FBO_RST_AVAIL,
      24'h21_0200: `FBO_RST_CONTROL, 24'h21_0300: `FBO_STATUS_COUNT,
      24'h21_0301: `FBO_RST_MASK, 24'h21_0302: `FBO_RST_ENABLED};
    repeat (2) @(negedge clk);
    enc_position = $urandom;
  endtask : rst
  task automatic acc(input logic w, input logic [23:0] k, input fbo_word_t d);
    fbo_word_t rd, e;
    logic ab, ea;
    e = mdl.exists(k) ? mdl[k] : 32'h0000_0000;
    ea = !mdl.exists(k) || (w && ro.exists(k));
    fbo_master_model_i.access(w, k[23:8], k[7:0], d, rd, ab);
    chk(rd, e);
    chk({31'h0, ab}, {31'h0, ea});
    if (w && mdl.exists(k) && !ro.exists(k))
      mdl[k] = d;
    if (w && k == 24'h21_0200)
      mdl[24'h21_0302] = mdl[24'h21_0302] & ~32'h0000_0008 | d & 32'h0000_0008;
    chk(fieldbus_enabled, mdl[24'h21_0302]);
    chk({31'h0, rotation_mode}, {31'h0, mdl[24'h20_5b00] == 1});
  endtask : acc
  initial
  begin
    void'($urandom(99));
    enc_position = $urandom;
    ro = '{24'h20_5a00: 1, 24'h21_0100: 1, 24'h21_0300: 1, 24'h21_0301: 1,
      24'h21_0302: 1};
    rst(12);
    repeat (2)
    begin
      foreach (keys[j])
        acc(1'b0, keys[j], 32'h0000_0000);
      chk({31'h0, func_ready}, 32'h0000_0001);
      foreach (ro[k])
        acc(1'b1, k, $urandom);
      acc(1'b0, 24'h20_0000, 32'h0000_0000);
      acc(1'b1, 24'h20_5b01, 32'h0000_0001);
      acc(1'b0, 24'h21_0303, 32'h0000_0000);
      repeat (30)
      begin
        acc(1'b1, 24'h20_5b00, $urandom % 3);
        acc(1'b1, 24'h20_8400, $urandom);
        acc(1'b1, 24'h21_0200, $urandom);
        acc(1'b0, 24'h21_0302, 32'h0000_0000);
      end
      foreach (keys[j])
        acc(1'b0, keys[j], 32'h0000_0000);
      rst(2);
    end
    results();
  end
endmodule : tb_top
